// File: verilog/dcc_top.sv
`timescale 1ns/1ps
//
// Contract
// [R1] enable bit turns comparator on
// [R2] output not valid until settle elapses
// [R3] software masks irq during settle
// [R4] hardware sets flag on synced change
// [R5] result bit synchronised to system clock
// [R6] raw result drives pin when enabled
// [R7] negative select: external pin or reference
// [R8] positive select: first or second pin
// [R9] result high when positive exceeds negative
// [R10] both flags share one interrupt
// [R11] irq needs comparator and global enable
// [R12] handler reads both flags
// [R13] disabled comparator result forced high
// [R14] rise on disable sets flag
// [R15] software disables irq before disabling
// [R16] total power-down disables both comparators
// [R17] set beats clear in same cycle
module dcc_top
(
   input  wire logic        clk_sys,       // 20 MHz system clock
   input  wire logic        rstn,          // synchronous reset, active low
   input  wire logic        psel,          // apb select
   input  wire logic        penable,       // apb enable
   input  wire logic        pwrite,        // apb direction
   input  wire logic [11:0] paddr,         // apb byte address
   input  wire logic [31:0] pwdata,        // apb write data
   output logic      [31:0] prdata,        // apb read data
   output logic             pready,        // apb ready
   output logic             pslverr,       // apb error
   input  wire logic        total_pd,      // total power-down request
   input  wire logic [1:0]  cmp_ext_first,  // per channel: first pin vs external ref
   input  wire logic [1:0]  cmp_ext_second, // per channel: second pin vs external ref
   input  wire logic [1:0]  cmp_ref_first,  // per channel: first pin vs internal ref
   input  wire logic [1:0]  cmp_ref_second, // per channel: second pin vs internal ref
   output logic      [1:0]  result_pin_out, // result output pin levels
   output logic      [1:0]  result_pin_oe,  // result output pin enables
   output logic      [1:0]  settled,        // settle period elapsed per channel
   output logic             irq            // shared comparator interrupt, level
);
   logic [5:2] ctrl_reg [2];  // enable, pos, neg, oe per channel
   logic       cie_reg;       // comparator irq enable
   logic       gie_reg;       // global irq enable
   logic [1:0] mask_reg;      // per-flag mask
   logic [1:0] synced;        // synced results
   logic [1:0] flag;          // change flags
   logic [1:0] flag_clr;      // clear pulses
   logic       wr_acc;        // write access phase
   logic       pd_s;          // power-down synchronised
   logic       hit;           // mapped address

   // power-down pin comes from outside, so synchronise it
   // pd_s is high while running, so it gates the enables directly
   dcc_sync u_pd
   (
      .clk_sys   (clk_sys),
      .rstn      (rstn),
      .async_in  (~total_pd),
      .reset_val (1'b1),
      .sync_out  (pd_s)
   );

   // no wait states: a write lands on the edge that ends its access
   // an unmapped address answers with an error and changes nothing
   assign wr_acc = psel & penable & pwrite;
   assign pready = 1'b1;     // zero wait states
   assign pslverr = psel & penable & ~hit;

   // address decode
   // full twelve-bit match, so the map has no aliases
   always_comb
   begin
      if (paddr == dcc_pkg::CMP_ONE_ADDR)
         hit = 1'b1;
      else if (paddr == dcc_pkg::CMP_TWO_ADDR)
         hit = 1'b1;
      else if (paddr == dcc_pkg::IRQ_CTRL_ADDR)
         hit = 1'b1;
      else if (paddr == dcc_pkg::IRQ_MASK_ADDR)
         hit = 1'b1;
      else
         hit = 1'b0;
   end

   // control register writes; enable steers the channel
   // only bits five to two are stored; the rest live in the channel
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         ctrl_reg[0] <= dcc_pkg::CTRL_RESET[5:2];
         ctrl_reg[1] <= dcc_pkg::CTRL_RESET[5:2];
      end
      else if (wr_acc && paddr == dcc_pkg::CMP_ONE_ADDR)
         ctrl_reg[0] <= pwdata[5:2];
      else if (wr_acc && paddr == dcc_pkg::CMP_TWO_ADDR)
         ctrl_reg[1] <= pwdata[5:2];
   end

   // irq control and mask writes
   // the mask resets open, so the enables alone decide at first
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         cie_reg  <= 1'b0;
         gie_reg  <= 1'b0;
         mask_reg <= dcc_pkg::MASK_RESET;
      end
      else if (wr_acc && paddr == dcc_pkg::IRQ_CTRL_ADDR)
      begin
         cie_reg <= pwdata[dcc_pkg::CIE_BIT];
         gie_reg <= pwdata[dcc_pkg::GIE_BIT];
      end
      else if (wr_acc && paddr == dcc_pkg::IRQ_MASK_ADDR)
         mask_reg <= pwdata[1:0];
   end

   // flag cleared by writing a one to bit zero; set still wins in the channel
   // a zero in bit zero leaves the flag alone, so rewriting a control word is safe
   assign flag_clr[0] = wr_acc && paddr == dcc_pkg::CMP_ONE_ADDR && pwdata[dcc_pkg::FLAG_BIT];
   assign flag_clr[1] = wr_acc && paddr == dcc_pkg::CMP_TWO_ADDR && pwdata[dcc_pkg::FLAG_BIT];

   // power-down gates each enable, whatever software wrote
   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : g_ch
         dcc_chan u_ch
         (
            .clk_sys        (clk_sys),
            .rstn           (rstn),
            .enable_eff     (ctrl_reg[g][dcc_pkg::EN_BIT] & pd_s),             // R1 R16
            .pos_sel        (ctrl_reg[g][dcc_pkg::POS_BIT]),
            .neg_sel        (ctrl_reg[g][dcc_pkg::NEG_BIT]),
            .oe             (ctrl_reg[g][dcc_pkg::OE_BIT]),
            .raw_pos_first  (cmp_ref_first[g]),
            .raw_pos_second (cmp_ref_second[g]),
            .raw_ext_first  (cmp_ext_first[g]),
            .raw_ext_second (cmp_ext_second[g]),
            .flag_clr       (flag_clr[g]),
            .pin_out        (result_pin_out[g]),
            .pin_oe         (result_pin_oe[g]),
            .synced         (synced[g]),
            .flag           (flag[g]),
            .settled        (settled[g])
         );
      end
   endgenerate

   // shared interrupt gated by both enables and mask
   // registered: irq follows an enable or flag change one clock later
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
         irq <= 1'b0;
      else
         irq <= cie_reg & gie_reg & |(flag & mask_reg);                        // R10 R11
   end

   // read mux, registered data
   // captured in the setup cycle; a flag that sets during the access
   // shows on the next read rather than half-way through this one
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
         prdata <= 32'h0000_0000;
      else if (psel && !penable && !pwrite)
      begin
         if (paddr == dcc_pkg::CMP_ONE_ADDR)
            prdata <= {26'h0, ctrl_reg[0], synced[0], flag[0]};
         else if (paddr == dcc_pkg::CMP_TWO_ADDR)
            prdata <= {26'h0, ctrl_reg[1], synced[1], flag[1]};
         else if (paddr == dcc_pkg::IRQ_CTRL_ADDR)
            prdata <= {26'h0, settled, flag, gie_reg, cie_reg};
         else if (paddr == dcc_pkg::IRQ_MASK_ADDR)
            prdata <= {30'h0, mask_reg};
         else
            prdata <= 32'h0000_0000;
      end
   end

   // irq follows flags one cycle later when both enables are set
   property p_irq_gate;
      @(posedge clk_sys) disable iff (!rstn)
      (cie_reg && gie_reg && |(flag & mask_reg)) |=> irq;
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq missing"); // R11

   property p_irq_off;
      @(posedge clk_sys) disable iff (!rstn)
      !gie_reg |=> !irq;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("irq without enable"); // R11

   property p_disabled_high;
      @(posedge clk_sys) disable iff (!rstn)
      !ctrl_reg[0][dcc_pkg::EN_BIT] [*6] |-> synced[0];
   endproperty
   a_disabled_high: assert property (p_disabled_high) else $error("result not high"); // R13

   property p_pin_gate;
      @(posedge clk_sys) disable iff (!rstn)
      !ctrl_reg[1][dcc_pkg::EN_BIT] |-> !result_pin_oe[1];
   endproperty
   a_pin_gate: assert property (p_pin_gate) else $error("pin driven"); // R6

   property p_flag_set;
      @(posedge clk_sys) disable iff (!rstn)
      $changed(synced[0]) |=> flag[0];
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag not set"); // R4

   property p_set_wins;
      @(posedge clk_sys) disable iff (!rstn)
      (flag_clr[1] && $changed(synced[1])) |=> flag[1];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("clear beat set"); // R17

   property p_clear;
      @(posedge clk_sys) disable iff (!rstn)
      (flag_clr[0] && !$changed(synced[0])) |=> !flag[0];
   endproperty
   a_clear: assert property (p_clear) else $error("clear sequence"); // R4

   property p_settle;
      @(posedge clk_sys) disable iff (!rstn)
      $rose(ctrl_reg[0][dcc_pkg::EN_BIT]) && pd_s |-> !settled[0] [*8];
   endproperty
   a_settle: assert property (p_settle) else $error("settled too early"); // R2

   property p_pd;
      @(posedge clk_sys) disable iff (!rstn)
      !pd_s |-> !result_pin_oe[0] && !result_pin_oe[1];
   endproperty
   a_pd: assert property (p_pd) else $error("active in power-down"); // R16

   // flag holds without a change or a clear
   property p_flag_hold_a;
      @(posedge clk_sys) disable iff (!rstn)
      (!flag_clr[0] && !$changed(synced[0])) |=> (flag[0] == $past(flag[0]));
   endproperty
   a_flag_hold_a: assert property (p_flag_hold_a) else $error("flag moved"); // R4

   // channel two sets its flag on a change
   property p_flag_set_b;
      @(posedge clk_sys) disable iff (!rstn)
      $changed(synced[1]) |=> flag[1];
   endproperty
   a_flag_set_b: assert property (p_flag_set_b) else $error("flag two not set"); // R4

   // a clear in the cycle of a change loses
   property p_set_wins_a;
      @(posedge clk_sys) disable iff (!rstn)
      (flag_clr[0] && $changed(synced[0])) |=> flag[0];
   endproperty
   a_set_wins_a: assert property (p_set_wins_a) else $error("clear beat set"); // R17

   // a plain clear empties the flag
   property p_clear_b;
      @(posedge clk_sys) disable iff (!rstn)
      (flag_clr[1] && !$changed(synced[1])) |=> !flag[1];
   endproperty
   a_clear_b: assert property (p_clear_b) else $error("flag two not cleared"); // R4

   // disabled channel two reads high
   property p_disabled_high_b;
      @(posedge clk_sys) disable iff (!rstn)
      !ctrl_reg[1][dcc_pkg::EN_BIT] [*6] |-> synced[1];
   endproperty
   a_disabled_high_b: assert property (p_disabled_high_b) else $error("result two not high"); // R13

   // power-down forces both results high
   property p_pd_high;
      @(posedge clk_sys) disable iff (!rstn)
      !pd_s [*6] |-> (synced[0] && synced[1]);
   endproperty
   a_pd_high: assert property (p_pd_high) else $error("result low in power-down"); // R16

   // no pin drive while channel one is off
   property p_pin_gate_a;
      @(posedge clk_sys) disable iff (!rstn)
      !ctrl_reg[0][dcc_pkg::EN_BIT] |-> !result_pin_oe[0];
   endproperty
   a_pin_gate_a: assert property (p_pin_gate_a) else $error("pin one driven"); // R6

   // pin drive needs the output enable bit
   property p_pin_oe_bit;
      @(posedge clk_sys) disable iff (!rstn)
      result_pin_oe[0] |-> ctrl_reg[0][dcc_pkg::OE_BIT];
   endproperty
   a_pin_oe_bit: assert property (p_pin_oe_bit) else $error("pin without oe"); // R6

   // channel two is not settled right after enable
   property p_settle_b;
      @(posedge clk_sys) disable iff (!rstn)
      $rose(ctrl_reg[1][dcc_pkg::EN_BIT]) && pd_s |-> !settled[1] [*8];
   endproperty
   a_settle_b: assert property (p_settle_b) else $error("two settled early"); // R2

   // settled stays while the channel runs
   property p_settle_hold;
      @(posedge clk_sys) disable iff (!rstn)
      (settled[0] && ctrl_reg[0][dcc_pkg::EN_BIT] && pd_s) |=> settled[0];
   endproperty
   a_settle_hold: assert property (p_settle_hold) else $error("settled dropped"); // R2

   // disabling restarts the settle period
   property p_settle_clear;
      @(posedge clk_sys) disable iff (!rstn)
      !ctrl_reg[1][dcc_pkg::EN_BIT] |=> !settled[1];
   endproperty
   a_settle_clear: assert property (p_settle_clear) else $error("settled while off"); // R2

   // comparator irq enable is needed too
   property p_irq_cie;
      @(posedge clk_sys) disable iff (!rstn)
      !cie_reg |=> !irq;
   endproperty
   a_irq_cie: assert property (p_irq_cie) else $error("irq without cie"); // R11

   // no unmasked flag, no interrupt
   property p_irq_none;
      @(posedge clk_sys) disable iff (!rstn)
      ((flag & mask_reg) == 2'b00) |=> !irq;
   endproperty
   a_irq_none: assert property (p_irq_none) else $error("irq without flag"); // R10

   // a read of channel one shows result and flag of setup
   property p_rd_one;
      @(posedge clk_sys) disable iff (!rstn)
      (psel && penable && !pwrite && paddr == dcc_pkg::CMP_ONE_ADDR)
         |-> (prdata[1:0] == $past({synced[0], flag[0]}));
   endproperty
   a_rd_one: assert property (p_rd_one) else $error("read one wrong"); // R5

   // a read of channel two shows result and flag of setup
   property p_rd_two;
      @(posedge clk_sys) disable iff (!rstn)
      (psel && penable && !pwrite && paddr == dcc_pkg::CMP_TWO_ADDR)
         |-> (prdata[1:0] == $past({synced[1], flag[1]}));
   endproperty
   a_rd_two: assert property (p_rd_two) else $error("read two wrong"); // R4
endmodule

// File: verilog/dcc_pkg.sv
package dcc_pkg;
   // register byte addresses (printed offsets ac/ad are indices, byte address = 4 x index)
   localparam logic [7:0]  CMP_ONE_IDX   = 8'hAC;  // comparator one control index
   localparam logic [7:0]  CMP_TWO_IDX   = 8'hAD;  // comparator two control index
   localparam logic [11:0] CMP_ONE_ADDR  = 12'h2B0; // 4 x 0xAC
   localparam logic [11:0] CMP_TWO_ADDR  = 12'h2B4; // 4 x 0xAD
   localparam logic [11:0] IRQ_CTRL_ADDR = 12'h2B8; // irq enables and status mirror
   localparam logic [11:0] IRQ_MASK_ADDR = 12'h2BC; // per-flag irq mask, freely rewritable
   // control register field positions
   localparam int FLAG_BIT = 0;  // change flag
   localparam int SYNC_BIT = 1;  // synced result
   localparam int OE_BIT   = 2;  // output pin enable
   localparam int NEG_BIT  = 3;  // negative input select
   localparam int POS_BIT  = 4;  // positive input select
   localparam int EN_BIT   = 5;  // comparator enable
   // irq control fields
   localparam int CIE_BIT  = 0;  // comparator irq enable
   localparam int GIE_BIT  = 1;  // global irq enable
   // reset values
   localparam logic [7:0]  CTRL_RESET = 8'h00; // control bits after reset
   localparam logic [1:0]  MASK_RESET = 2'h3;  // both flags pass by default
   // settling time
   localparam int SETTLE_NS = 10000; // 10 microseconds
   localparam int CLK_NS    = 50;    // 20 MHz period
   localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS; // rounds up, 200
   // input synchroniser depth
   localparam int SYNC_STAGES = 3;
endpackage

// File: verilog/dcc_sync.sv
`timescale 1ns/1ps
// three-stage synchroniser; a change counts once the last two stages agree
module dcc_sync
(
   input  wire logic clk_sys, // system clock
   input  wire logic rstn,    // synchronous reset, active low
   input  wire logic async_in, // asynchronous level
   input  wire logic reset_val, // level assumed during reset
   output logic      sync_out  // filtered synchronous level
);
   logic [dcc_pkg::SYNC_STAGES-1:0] stage_reg; // stage 0 read only by stage 1

   // shift chain; reset value is a constant per instance tie-off
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
         stage_reg <= {dcc_pkg::SYNC_STAGES{reset_val}};
      else
         stage_reg <= {stage_reg[1:0], async_in};
   end

   // accept a change only when stages two and three agree
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
         sync_out <= reset_val;
      else if (stage_reg[1] == stage_reg[2])
         sync_out <= stage_reg[2];
   end
endmodule

// File: verilog/dcc_chan.sv
`timescale 1ns/1ps
// one comparator channel: selection, gating, settle timer, sync and change flag
module dcc_chan
(
   input  wire logic       clk_sys,     // system clock
   input  wire logic       rstn,        // synchronous reset, active low
   input  wire logic       enable_eff,  // enable bit and not total power-down
   input  wire logic       pos_sel,     // positive input select
   input  wire logic       neg_sel,     // negative input select
   input  wire logic       oe,          // output pin enable
   input  wire logic       raw_pos_first,  // analog result, first pin vs internal reference
   input  wire logic       raw_pos_second, // analog result, second pin vs internal reference
   input  wire logic       raw_ext_first,  // first pin vs external reference
   input  wire logic       raw_ext_second, // second pin vs external reference
   input  wire logic       flag_clr,    // software clear of change flag
   output logic            pin_out,     // result output pin level
   output logic            pin_oe,      // result output pin enable
   output logic            synced,      // synced result bit
   output logic            flag,        // change flag
   output logic            settled      // settling period elapsed
);
   logic raw_sel;     // selected raw result
   logic raw_gated;   // forced high while disabled
   logic synced_prev; // previous synced value for edge detect
   logic [$clog2(dcc_pkg::SETTLE_CYC+1)-1:0] settle_cnt; // settle counter

   // input mux: positive and negative selects choose the comparison
   always_comb
   begin
      case ({neg_sel, pos_sel})                                                 // R7 R8
         2'b00:   raw_sel = raw_ext_first;
         2'b01:   raw_sel = raw_ext_second;
         2'b10:   raw_sel = raw_pos_first;
         default: raw_sel = raw_pos_second;
      endcase
   end

   // result is one when positive exceeds negative; disabled forces high
   assign raw_gated = enable_eff ? raw_sel : 1'b1;                            // R1 R9 R13

   // asynchronous pin path, only with enable and output enable
   assign pin_oe  = enable_eff & oe;                                          // R6
   assign pin_out = raw_sel;                                                  // R6

   dcc_sync u_sync
   (
      .clk_sys   (clk_sys),
      .rstn      (rstn),
      .async_in  (raw_gated),
      .reset_val (1'b1),
      .sync_out  (synced)                                                     // R5
   );

   // settle counter restarts every time the channel is disabled
   always_ff @(posedge clk_sys)
   begin
      if (!rstn || !enable_eff)
         settle_cnt <= '0;
      else if (settle_cnt != ($bits(settle_cnt))'(dcc_pkg::SETTLE_CYC))
         settle_cnt <= settle_cnt + 1'b1;
   end
   assign settled = (settle_cnt == ($bits(settle_cnt))'(dcc_pkg::SETTLE_CYC)); // R2

   // edge history of synced result
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
         synced_prev <= 1'b1;
      else
         synced_prev <= synced;
   end

   // change flag: set wins over clear, including disable rise
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
         flag <= 1'b0;
      else if (synced != synced_prev)                                         // R4 R14 R17
         flag <= 1'b1;
      else if (flag_clr)
         flag <= 1'b0;
   end
endmodule

// File: verification/dcc_analog.sv
`timescale 1ns/1ps
// analog front end: turns pin voltages into the four comparison levels
module dcc_analog
#(
   parameter int VREF_MV = 600 // internal reference, plain default
)
(
   input  wire logic [1:0][9:0] v_first,    // first positive pin, mV
   input  wire logic [1:0][9:0] v_second,   // second positive pin, mV
   input  wire logic [1:0][9:0] v_ext,      // external reference pin, mV
   output logic      [1:0]      ext_first,  // first pin vs external
   output logic      [1:0]      ext_second, // second pin vs external
   output logic      [1:0]      ref_first,  // first pin vs internal
   output logic      [1:0]      ref_second  // second pin vs internal
);
   // strictly greater reads high; equal voltages read low
   always_comb
   begin
      for (int c = 0; c < 2; c++)
      begin
         ext_first[c]  = v_first[c] > v_ext[c];
         ext_second[c] = v_second[c] > v_ext[c];
         ref_first[c]  = v_first[c] > 10'(VREF_MV);
         ref_second[c] = v_second[c] > 10'(VREF_MV);
      end
   end
endmodule

// File: verification/dcc_top_test.sv
`timescale 1ns/1ps
// driver notes expected reads in a queue; a monitor compares them
module dcc_top_test;
   localparam int VREF  = 600;   // internal reference of the model
   localparam int LIMIT = 30000; // run needs under 8000 cycles
   logic            clk_sys  = 1'b0;  // 50 ns clock
   logic            rstn     = 1'b0;  // held low at start
   logic            psel     = 1'b0;  // apb select
   logic            penable  = 1'b0;  // apb enable
   logic            pwrite   = 1'b0;  // apb direction
   logic [11:0]     paddr    = 12'h000;
   logic [31:0]     pwdata   = 32'h00000000;
   logic            total_pd = 1'b0;  // power-down request
   logic [1:0][9:0] v_a      = '0;    // first pins, mV
   logic [1:0][9:0] v_b      = '0;    // second pins, mV
   logic [1:0][9:0] v_x      = '0;    // external reference, mV
   logic [31:0]     prdata;           // apb read data
   logic            pready;           // apb ready
   logic            pslverr;          // apb error
   logic [1:0]      ef, es, rf, rs;   // comparison levels
   logic [1:0]      pin_out, pin_oe;  // result pins
   logic [1:0]      settled;          // settle done
   logic            irq;              // shared interrupt
   logic [31:0]     exp_q[$];         // expected read words
   logic [31:0]     msk_q[$];         // bits that matter
   int              n_mismatch = 0;
   int              cmp_count  = 0;
   int              seed       = 82463;
   int              cyc        = 0;   // timeout counter
   logic            last_err;         // pslverr of last transfer

   always #25 clk_sys = ~clk_sys;

   dcc_top i_dcc_top (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .total_pd(total_pd), .cmp_ext_first(ef), .cmp_ext_second(es), .cmp_ref_first(rf),
      .cmp_ref_second(rs), .result_pin_out(pin_out), .result_pin_oe(pin_oe), .settled(settled), .irq(irq));
   dcc_analog #(.VREF_MV(VREF)) i_dcc_analog (.v_first(v_a), .v_second(v_b), .v_ext(v_x),
      .ext_first(ef), .ext_second(es), .ref_first(rf), .ref_second(rs));

   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      last_err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   // note first; the monitor compares when the read completes
   task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
      exp_q.push_back(e & m);
      msk_q.push_back(m);
      apb(1'b0, a, 32'h0);
   endtask

   // wait, then sample on the falling edge where outputs are settled
   task automatic ticks(input int n);
      repeat (n) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask

   function automatic logic [11:0] ca(input int c);
      return c ? dcc_pkg::CMP_TWO_ADDR : dcc_pkg::CMP_ONE_ADDR;
   endfunction

   function automatic logic [31:0] cw(input logic en, input logic p, input logic n, input logic o);
      return {26'h0, en, p, n, o, 2'b00};
   endfunction

   function automatic logic res(input int c, input logic p, input logic n);
      return (p ? v_b[c] : v_a[c]) > (n ? 10'(VREF) : v_x[c]);
   endfunction

   // enable with the irq off, time the settle, clear the flag
   task automatic settle(input int c, input logic [31:0] w);
      int n = 0;
      wr(dcc_pkg::IRQ_CTRL_ADDR, 32'h0);
      wr(ca(c), w);
      while (settled[c] !== 1'b1 && n < 400)
      begin
         @(negedge clk_sys);
         n++;
      end
      // first wait falls in the cycle of the write itself
      chk(32'(n), 32'(dcc_pkg::SETTLE_CYC + 1));
      wr(ca(c), w | 32'h1);
   endtask

   // read monitor and hang guard
   always @(posedge clk_sys)
   begin
      cyc++;
      if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
         chk(prdata & msk_q.pop_front(), exp_q.pop_front());
      if (cyc == LIMIT)
      begin
         n_mismatch++;
         report_and_stop();
      end
   end

   initial
   begin
      logic e;
      repeat (12) @(posedge clk_sys);
      rstn <= 1'b1;
      rd(dcc_pkg::CMP_ONE_ADDR, 32'h0, 32'h3C);
      rd(dcc_pkg::IRQ_MASK_ADDR, 32'h3, 32'h3);
      rd(dcc_pkg::IRQ_CTRL_ADDR, 32'h0, 32'h3);
      rd(12'h300, 32'h0, 32'hFFFFFFFF);
      chk(last_err, 1);
      for (int c = 0; c < 2; c++)
      begin
         settle(c, cw(1, 0, 0, 1));
         // random voltages across every input selection
         for (int i = 0; i < 12; i++)
         begin
            wr(ca(c), cw(1, i[1], i[0], i[2]));
            v_a[c] <= 10'($random(seed));
            v_b[c] <= 10'($random(seed));
            v_x[c] <= 10'($random(seed));
            ticks(8);
            e = res(c, i[1], i[0]);
            chk(pin_oe[c], i[2]);
            if (i[2])
               chk(pin_out[c], e);
            rd(ca(c), 32'(e) << 1, 32'h2);
         end
         // low result, clear, then a rise sets the flag
         wr(ca(c), cw(1, 0, 0, 1));
         v_a[c] <= 10'd100;
         v_x[c] <= 10'd500;
         ticks(8);
         wr(ca(c), cw(1, 0, 0, 1) | 32'h1);
         v_a[c] <= 10'd900;
         ticks(8);
         rd(ca(c), 32'h3, 32'h3);
         wr(dcc_pkg::IRQ_MASK_ADDR, 32'(1 << c));
         wr(dcc_pkg::IRQ_CTRL_ADDR, 32'h1);
         ticks(2);
         chk(irq, 0);
         wr(dcc_pkg::IRQ_CTRL_ADDR, 32'h3);
         ticks(2);
         chk(irq, 1);
         rd(dcc_pkg::IRQ_CTRL_ADDR, 32'(4 << c), 32'(4 << c));
         wr(dcc_pkg::IRQ_MASK_ADDR, 32'h0);
         ticks(2);
         chk(irq, 0);
         wr(dcc_pkg::IRQ_MASK_ADDR, 32'(1 << c));
         // result low, flag cleared, then disable with irq on
         v_a[c] <= 10'd100;
         ticks(8);
         wr(ca(c), cw(1, 0, 0, 1) | 32'h1);
         ticks(2);
         chk(irq, 0);
         rd(ca(c), 32'h0, 32'h3);
         wr(ca(c), cw(0, 0, 0, 1));
         ticks(8);
         rd(ca(c), 32'h3, 32'h3);
         chk(pin_oe[c], 0);
         chk(irq, 1);
         wr(dcc_pkg::IRQ_CTRL_ADDR, 32'h0);
         wr(ca(c), 32'h1);
      end
      // total power-down overrides the enable bit
      settle(0, cw(1, 0, 0, 1));
      v_a[0] <= 10'd100;
      ticks(8);
      @(posedge clk_sys);
      total_pd <= 1'b1;
      ticks(8);
      chk(pin_oe[0], 0);
      rd(ca(0), 32'h2, 32'h2);
      @(posedge clk_sys);
      total_pd <= 1'b0;
      ticks(4);
      report_and_stop();
   end
endmodule
